// >>> rtl/rts_pkg.sv
package rts_pkg;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned PWRUP_DELAY_MS = 72;
    localparam int unsigned BOR_MIN_US = 100;
    // Internal RC ticks per millisecond and per microsecond.
    localparam int unsigned RC_TICKS_PER_MS = 1000;
    localparam int unsigned PWRUP_TICKS = PWRUP_DELAY_MS * RC_TICKS_PER_MS;
    localparam int unsigned BOR_TICKS_DFLT = BOR_MIN_US;
    localparam int unsigned OST_CYCLES = 1024;
    localparam int unsigned MASTER_CLEAR_PIN_FILT_CYCLES = 4;
    localparam int unsigned CNT_W = 17;

    // ---------------------------------------------------------------
    // Register map and reset values
    // ---------------------------------------------------------------
    localparam logic [11:0] PWR_STAT_OFS = 12'h000;
    localparam logic [11:0] SPEC_OFS = 12'h004;
    localparam logic [11:0] CFG_OFS = 12'h008;
    localparam int unsigned BORN_BIT = 0;
    localparam int unsigned PORN_BIT = 1;
    localparam logic [12:0] PC_RESET = 13'h0000;
    localparam logic [12:0] PC_IRQ_VEC = 13'h0004;
    localparam logic [7:0] STATUS_POR = 8'h18;
    localparam logic [7:0] OPTION_RESET = 8'hff;
    localparam logic [7:0] TRIS_RESET = 8'hff;
    localparam logic [3:0] CFG_RESET = 4'h0;

    typedef enum logic [1:0] {
        RTS_OSC_LP = 2'b00,
        RTS_OSC_XT = 2'b01,
        RTS_OSC_HS = 2'b10,
        RTS_OSC_RC = 2'b11
    } rts_osc_t;

    typedef enum logic [2:0] {
        RTS_ST_HOLD = 3'b000,
        RTS_ST_POWERUP_DELAY_TIMER = 3'b001,
        RTS_ST_OST = 3'b010,
        RTS_ST_WAIT = 3'b011,
        RTS_ST_RUN = 3'b100
    } rts_state_t;

    // Reset-cause events seen by the sequencer.
    typedef struct packed {
        logic por;
        logic wdt_reset;
        logic wdt_wake;
        logic irq_wake;
        logic sleeping;
    } rts_evt_t;

    typedef struct packed {
        rts_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] bor_cnt;
        logic in_bor;
        logic master_clear_pin_sync;
        logic [2:0] master_clear_pin_cnt;
        logic master_clear_pin_ok;
        logic [1:0] power_reset_status;
        logic to_flag;
        logic pd_flag;
        logic [12:0] pc;
        logic [7:0] status;
        logic [7:0] option;
        logic [7:0] tris;
        logic load_pulse;
        logic [31:0] prdata;
    } rts_state_s_t;

endpackage : rts_pkg

// >>> rtl/rts_sequencer.sv
`timescale 1ns/1ps
module rts_sequencer #(
    parameter int unsigned PWRUP_TICKS = rts_pkg::PWRUP_TICKS,
    parameter int unsigned BOR_TICKS = rts_pkg::BOR_TICKS_DFLT
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic por_pulse_i,
    input wire logic vdd_low_i,
    input wire logic brownout_enable_cfg_i,
    input wire logic powerup_timer_enable_n_i,
    input wire logic [1:0] osc_mode_i,
    input wire logic rc_tick_i,
    input wire logic osc_input_pin_i,
    input wire logic master_clear_pin_n_i,
    input wire logic wdt_timeout_i,
    input wire logic sleeping_i,
    input wire logic irq_wake_i,
    input wire logic global_irq_enable_i,
    input wire logic [12:0] cur_pc_i,
    output logic chip_reset_o,
    output logic [12:0] pc_o,
    output logic pc_load_o,
    output logic [7:0] status_o,
    output logic [7:0] option_o,
    output logic [7:0] tris_o
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    rts_pkg::rts_state_s_t q_r;
    rts_pkg::rts_state_s_t q_nxt;
    logic osc_d_r;
    logic osc_rise;
    logic crystal;
    logic powerup_delay_timer_on;
    logic bor_hit;
    logic wr;
    logic rd;

    // Crystal modes need the oscillator start-up count.
    function automatic logic is_crystal(input logic [1:0] m);
        is_crystal = (m != rts_pkg::RTS_OSC_RC);
    endfunction : is_crystal

    // Oscillator edge detector; the pin is taken as synchronous.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            osc_d_r <= 1'b0;
        end else begin
            osc_d_r <= osc_input_pin_i;
        end
    end

    assign osc_rise = osc_input_pin_i & ~osc_d_r;
    assign crystal = is_crystal(osc_mode_i);
    // Brown-out enable forces the delay whatever the timer bit says.
    assign powerup_delay_timer_on = ~powerup_timer_enable_n_i | brownout_enable_cfg_i;
    assign bor_hit = brownout_enable_cfg_i & vdd_low_i
        & (q_r.bor_cnt >= BOR_TICKS[rts_pkg::CNT_W-1:0] - 1'b1) & rc_tick_i;
    assign wr = psel_i & penable_i & pwrite_i;
    assign rd = psel_i & ~penable_i & ~pwrite_i;

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    // Zero-wait APB: every access completes in its first access cycle.
    always_comb begin
        q_nxt = q_r;
        q_nxt.load_pulse = 1'b0;

        // Pin filter: the low level must persist before it counts.
        q_nxt.master_clear_pin_sync = master_clear_pin_n_i;
        if (q_r.master_clear_pin_sync) begin
            q_nxt.master_clear_pin_cnt = 3'h0;
            q_nxt.master_clear_pin_ok = 1'b1;
        end else if (q_r.master_clear_pin_cnt != 3'(rts_pkg::MASTER_CLEAR_PIN_FILT_CYCLES)) begin
            q_nxt.master_clear_pin_cnt = q_r.master_clear_pin_cnt + 3'h1;
        end else begin
            q_nxt.master_clear_pin_ok = 1'b0;
        end

        // Brown-out persistence window on RC ticks.
        if (!(brownout_enable_cfg_i && vdd_low_i)) begin
            q_nxt.bor_cnt = '0;
        end else if (rc_tick_i && !bor_hit) begin
            q_nxt.bor_cnt = q_r.bor_cnt + 1'b1;
        end

        case (q_r.st)
            rts_pkg::RTS_ST_HOLD: begin
                // Waiting for supply to recover after a brown-out dip; after power-on this is one cycle.
                if (!(q_r.in_bor && vdd_low_i)) begin
                    q_nxt.cnt = '0;
                    if (powerup_delay_timer_on) begin
                        q_nxt.st = rts_pkg::RTS_ST_POWERUP_DELAY_TIMER;
                    end else if (crystal) begin
                        q_nxt.st = rts_pkg::RTS_ST_OST;
                    end else begin
                        q_nxt.st = rts_pkg::RTS_ST_WAIT;
                    end
                end
            end
            rts_pkg::RTS_ST_POWERUP_DELAY_TIMER: begin
                if (q_r.in_bor && vdd_low_i) begin
                    q_nxt.st = rts_pkg::RTS_ST_HOLD;
                end else if (rc_tick_i) begin
                    q_nxt.cnt = q_r.cnt + 1'b1;
                    if (q_r.cnt == rts_pkg::CNT_W'(PWRUP_TICKS - 1)) begin
                        q_nxt.cnt = '0;
                        q_nxt.st = crystal ? rts_pkg::RTS_ST_OST
                            : rts_pkg::RTS_ST_WAIT;
                    end
                end
            end
            rts_pkg::RTS_ST_OST: begin
                if (osc_rise) begin
                    q_nxt.cnt = q_r.cnt + 1'b1;
                    if (q_r.cnt == rts_pkg::CNT_W'(rts_pkg::OST_CYCLES - 1)) begin
                        q_nxt.st = rts_pkg::RTS_ST_WAIT;
                    end
                end
            end
            rts_pkg::RTS_ST_WAIT: begin
                // Timeouts done; wait only for the pin to be high.
                if (q_r.master_clear_pin_ok) begin
                    q_nxt.st = rts_pkg::RTS_ST_RUN;
                    q_nxt.in_bor = 1'b0;
                end
            end
            rts_pkg::RTS_ST_RUN: begin
                if (!q_r.master_clear_pin_ok || wdt_timeout_i) begin
                    // Pin or watchdog reset: no start-up timers run.
                    q_nxt.st = sleeping_i && wdt_timeout_i
                        ? rts_pkg::RTS_ST_RUN : rts_pkg::RTS_ST_WAIT;
                end
            end
            default: begin
                q_nxt.st = rts_pkg::RTS_ST_HOLD;
            end
        endcase

        // Wake from sleep in crystal modes runs the start-up count.
        if (q_r.st == rts_pkg::RTS_ST_RUN && sleeping_i
            && (wdt_timeout_i || irq_wake_i) && crystal) begin
            q_nxt.st = rts_pkg::RTS_ST_OST;
            q_nxt.cnt = '0;
        end

        // Special registers per reset cause.
        if (q_r.st == rts_pkg::RTS_ST_RUN) begin
            if (!q_r.master_clear_pin_ok && sleeping_i) begin
                q_nxt.to_flag = 1'b1;
                q_nxt.pd_flag = 1'b0;
                q_nxt.status = {3'b000, 2'b10, q_r.status[2:0]};
                q_nxt.pc = rts_pkg::PC_RESET;
                q_nxt.option = rts_pkg::OPTION_RESET;
                q_nxt.tris = rts_pkg::TRIS_RESET;
                q_nxt.load_pulse = 1'b1;
            end else if (!q_r.master_clear_pin_ok) begin
                q_nxt.status = {3'b000, q_r.status[4:0]};
                q_nxt.pc = rts_pkg::PC_RESET;
                q_nxt.option = rts_pkg::OPTION_RESET;
                q_nxt.tris = rts_pkg::TRIS_RESET;
                q_nxt.load_pulse = 1'b1;
            end else if (wdt_timeout_i && sleeping_i) begin
                q_nxt.to_flag = 1'b0;
                q_nxt.pd_flag = 1'b0;
                q_nxt.status = {q_r.status[7:5], 2'b00, q_r.status[2:0]};
                q_nxt.pc = cur_pc_i + 13'h0001;
                q_nxt.load_pulse = 1'b1;
            end else if (wdt_timeout_i) begin
                q_nxt.to_flag = 1'b0;
                q_nxt.pd_flag = 1'b1;
                q_nxt.status = {3'b000, 2'b01, q_r.status[2:0]};
                q_nxt.pc = rts_pkg::PC_RESET;
                q_nxt.option = rts_pkg::OPTION_RESET;
                q_nxt.tris = rts_pkg::TRIS_RESET;
                q_nxt.load_pulse = 1'b1;
            end else if (irq_wake_i && sleeping_i) begin
                q_nxt.to_flag = 1'b1;
                q_nxt.pd_flag = 1'b0;
                q_nxt.status = {q_r.status[7:5], 2'b10, q_r.status[2:0]};
                q_nxt.pc = global_irq_enable_i ? rts_pkg::PC_IRQ_VEC
                    : cur_pc_i + 13'h0001;
                q_nxt.load_pulse = 1'b1;
            end
        end

        // Software sets the active-low flags; hardware clears win.
        if (wr && paddr_i == rts_pkg::PWR_STAT_OFS) begin
            q_nxt.power_reset_status = q_r.power_reset_status | pwdata_i[1:0];
        end

        // Brown-out entry: restart everything, clear the flag.
        if (bor_hit) begin
            q_nxt.st = rts_pkg::RTS_ST_HOLD;
            q_nxt.in_bor = 1'b1;
            q_nxt.cnt = '0;
            q_nxt.bor_cnt = '0;
            q_nxt.power_reset_status[rts_pkg::BORN_BIT] = 1'b0;
            q_nxt.to_flag = 1'b1;
            q_nxt.pd_flag = 1'b1;
            q_nxt.status = {3'b000, 2'b11, q_r.status[2:0]};
            q_nxt.pc = rts_pkg::PC_RESET;
            q_nxt.option = rts_pkg::OPTION_RESET;
            q_nxt.tris = rts_pkg::TRIS_RESET;
            q_nxt.load_pulse = 1'b1;
        end

        // Power-on pulse overrides all other causes; a same-cycle brown-out still clears its flag.
        if (por_pulse_i) begin
            q_nxt.st = rts_pkg::RTS_ST_HOLD;
            q_nxt.in_bor = 1'b0;
            q_nxt.cnt = '0;
            q_nxt.power_reset_status[rts_pkg::PORN_BIT] = 1'b0;
            q_nxt.to_flag = 1'b1;
            q_nxt.pd_flag = 1'b1;
            q_nxt.status = rts_pkg::STATUS_POR;
            q_nxt.pc = rts_pkg::PC_RESET;
            q_nxt.option = rts_pkg::OPTION_RESET;
            q_nxt.tris = rts_pkg::TRIS_RESET;
            q_nxt.load_pulse = 1'b1;
        end

        // Read data is captured in the setup cycle and stands until the
        // next read setup, so a late sample in the access phase is safe.
        if (rd) begin
            case (paddr_i)
                rts_pkg::PWR_STAT_OFS: q_nxt.prdata = {30'h0, q_r.power_reset_status};
                rts_pkg::SPEC_OFS: q_nxt.prdata = {14'h0, q_r.to_flag,
                    q_r.pd_flag, q_r.status, q_r.st, 5'h00};
                rts_pkg::CFG_OFS: q_nxt.prdata = {27'h0, brownout_enable_cfg_i,
                    powerup_timer_enable_n_i, osc_mode_i, powerup_delay_timer_on};
                default: q_nxt.prdata = '0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            q_r <= '{st: rts_pkg::RTS_ST_HOLD, cnt: '0, bor_cnt: '0,
                in_bor: 1'b0, master_clear_pin_sync: 1'b1, master_clear_pin_cnt: 3'h0,
                master_clear_pin_ok: 1'b1, power_reset_status: 2'b00, to_flag: 1'b1, pd_flag: 1'b1,
                pc: rts_pkg::PC_RESET, status: rts_pkg::STATUS_POR,
                option: rts_pkg::OPTION_RESET, tris: rts_pkg::TRIS_RESET,
                load_pulse: 1'b0, prdata: '0};
        end else begin
            q_r <= q_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Reset stays high until every timer and source has cleared.
    assign chip_reset_o = (q_r.st != rts_pkg::RTS_ST_RUN);
    assign pc_o = q_r.pc;
    assign pc_load_o = q_r.load_pulse;
    assign status_o = q_r.status;
    assign option_o = q_r.option;
    assign tris_o = q_r.tris;
    assign prdata_o = q_r.prdata;
    assign pready_o = 1'b1;
    assign pslverr_o = 1'b0;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_powerup_delay_timer_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (q_r.st == rts_pkg::RTS_ST_POWERUP_DELAY_TIMER) |-> chip_reset_o)
        else $error("reset released during power-up delay");
    chk_por_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        por_pulse_i |=> !q_r.power_reset_status[1] && q_r.to_flag && q_r.pd_flag)
        else $error("power-on flags wrong");
    chk_bor_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (bor_hit && !por_pulse_i) |=> !q_r.power_reset_status[0]
        && q_r.st == rts_pkg::RTS_ST_HOLD)
        else $error("brown-out not taken");
    chk_ost_count: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (q_r.st == rts_pkg::RTS_ST_OST && osc_rise && !bor_hit
        && !por_pulse_i && q_r.cnt == 17'd1023)
        |=> q_r.st == rts_pkg::RTS_ST_WAIT)
        else $error("start-up count end missed");
    chk_rc_no_ost: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !crystal && $stable(osc_mode_i) |-> ##1
        (q_r.st != rts_pkg::RTS_ST_OST || $past(q_r.st)
        == rts_pkg::RTS_ST_OST))
        else $error("start-up count in RC mode");
    chk_pin_release: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (q_r.st == rts_pkg::RTS_ST_WAIT && q_r.master_clear_pin_ok && !bor_hit
        && !por_pulse_i) |=> !chip_reset_o)
        else $error("release not immediate");
    chk_wdt_flags: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (q_r.st == rts_pkg::RTS_ST_RUN && q_r.master_clear_pin_ok && wdt_timeout_i
        && !sleeping_i && !bor_hit && !por_pulse_i)
        |=> !q_r.to_flag && q_r.pd_flag && q_r.pc == 13'h0000)
        else $error("watchdog reset flags wrong");
    chk_irq_vector: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (q_r.st == rts_pkg::RTS_ST_RUN && q_r.master_clear_pin_ok && !wdt_timeout_i
        && irq_wake_i && sleeping_i && global_irq_enable_i && !bor_hit
        && !por_pulse_i) |=> q_r.pc == 13'h0004)
        else $error("interrupt vector not loaded");

endmodule : rts_sequencer

// >>> bench/rts_sequencer_test.sv
`timescale 1ns/1ps
module rts_sequencer_test;
    // ---------------------------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------------------------
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic por_pulse_i = 1'b0;
    logic vdd_low_i = 1'b0;
    logic bor_en = 1'b1;
    logic powerup_timer_enable_n_n = 1'b0;
    logic [1:0] osc_mode_i = 2'h1;
    logic rc_tick_i = 1'b0;
    logic osc_pin = 1'b0;
    logic master_clear_pin_n = 1'b1;
    logic wdt_i = 1'b0;
    logic sleeping_i = 1'b0;
    logic irq_wake_i = 1'b0;
    logic global_irq_enable = 1'b0;
    logic [12:0] cur_pc_i = 13'h0000;
    logic chip_reset_o;
    logic [12:0] pc_o;
    logic pc_load_o;
    logic [7:0] status_o;
    logic [7:0] option_o;
    logic [7:0] tris_o;
    logic [1:0] tdiv = 2'h0;
    logic [31:0] d;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;

    // Shortened counts keep each start-up to a few thousand cycles.
    rts_sequencer #(.PWRUP_TICKS(20), .BOR_TICKS(4)) rts_sequencer_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .por_pulse_i(por_pulse_i),
        .vdd_low_i(vdd_low_i), .brownout_enable_cfg_i(bor_en),
        .powerup_timer_enable_n_i(powerup_timer_enable_n_n), .osc_mode_i(osc_mode_i),
        .rc_tick_i(rc_tick_i), .osc_input_pin_i(osc_pin),
        .master_clear_pin_n_i(master_clear_pin_n), .wdt_timeout_i(wdt_i),
        .sleeping_i(sleeping_i), .irq_wake_i(irq_wake_i),
        .global_irq_enable_i(global_irq_enable), .cur_pc_i(cur_pc_i),
        .chip_reset_o(chip_reset_o), .pc_o(pc_o), .pc_load_o(pc_load_o),
        .status_o(status_o), .option_o(option_o), .tris_o(tris_o));

    // ---------------------------------------------------------------
    // Clock, RC tick source and hang guard
    // ---------------------------------------------------------------
    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // One RC tick every four system cycles; a hang is cut at the ceiling.
    always @(posedge clk_sys_i) begin
        tdiv <= tdiv + 2'h1;
        rc_tick_i <= (tdiv == 2'h3);
        cycles++;
        if (cycles == 40000) begin
            fails++;
            results();
        end
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is sampled high or 20 access cycles pass.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int i;
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys_i);
            if (pready_o === 1'b1) break;
        end
        rd = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic osc_rises(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            osc_pin <= 1'b1;
            @(posedge clk_sys_i);
            osc_pin <= 1'b0;
        end
    endtask : osc_rises

    task automatic wait_rel(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge clk_sys_i);
            if (chip_reset_o === 1'b0) break;
        end
        chk("chip_reset released", 32'h0, 32'(chip_reset_o));
    endtask : wait_rel

    task automatic hold_chk(input int n, input string nm);
        repeat (n) @(posedge clk_sys_i);
        chk(nm, 32'h1, 32'(chip_reset_o));
    endtask : hold_chk

    task automatic flags(input logic [1:0] e);
        apb(1'b0, 12'h004, 32'h0, d);
        chk("expiry and powerdown", 32'(e), 32'(d[17:16]));
    endtask : flags

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_values();
        chk("status", 32'h18, 32'(status_o));
        chk("option", 32'hff, 32'(option_o));
        chk("tris", 32'hff, 32'(tris_o));
        chk("pc", 32'h0, 32'(pc_o));
        hold_chk(1, "chip_reset at power-on");
    endtask : t_reset_values

    // Crystal power-up: the 1024th oscillator rise is the boundary.
    task automatic t_xtal_powerup();
        hold_chk(120, "chip_reset after delay");
        osc_rises(1023);
        hold_chk(1, "chip_reset at 1023 rises");
        osc_rises(1);
        wait_rel(10);
        flags(2'b11);
        apb(1'b0, 12'h000, 32'h0, d);
        chk("power_reset_status", 32'h0, d);
    endtask : t_xtal_powerup

    task automatic t_power_reset_status_rw();
        apb(1'b1, 12'h000, 32'h3, d);
        apb(1'b0, 12'h000, 32'h0, d);
        chk("power_reset_status set", 32'h3, d);
        apb(1'b1, 12'h0f0, 32'hffffffff, d);
        apb(1'b0, 12'h0f0, 32'h0, d);
        chk("unmapped read", 32'h0, d);
        chk("pslverr", 32'h0, 32'(pslverr_o));
        apb(1'b0, 12'h008, 32'h0, d);
        chk("config echo", 32'h13, d);
    endtask : t_power_reset_status_rw

    task automatic t_brownout();
        @(posedge clk_sys_i);
        vdd_low_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        vdd_low_i <= 1'b0;
        repeat (8) @(posedge clk_sys_i);
        chk("short dip", 32'h0, 32'(chip_reset_o));
        vdd_low_i <= 1'b1;
        hold_chk(40, "chip_reset in brown-out");
        vdd_low_i <= 1'b0;
        hold_chk(40, "chip_reset in post delay");
        vdd_low_i <= 1'b1;
        repeat (40) @(posedge clk_sys_i);
        vdd_low_i <= 1'b0;
        hold_chk(60, "chip_reset after restart");
        repeat (60) @(posedge clk_sys_i);
        osc_rises(1024);
        wait_rel(20);
        apb(1'b0, 12'h000, 32'h0, d);
        chk("power_reset_status bor", 32'h2, d);
        flags(2'b11);
        chk("status bor", 32'h03, 32'(status_o[7:3]));
    endtask : t_brownout

    // RC mode with the pin held low: timeouts expire, the pin releases.
    task automatic t_master_clear_pin();
        @(posedge clk_sys_i);
        osc_mode_i <= 2'h3;
        powerup_timer_enable_n_n <= 1'b1;
        master_clear_pin_n <= 1'b0;
        por_pulse_i <= 1'b1;
        @(posedge clk_sys_i);
        por_pulse_i <= 1'b0;
        hold_chk(40, "forced delay");
        hold_chk(120, "chip_reset pin low");
        master_clear_pin_n <= 1'b1;
        wait_rel(20);
        master_clear_pin_n <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        master_clear_pin_n <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        chk("short pin pulse", 32'h0, 32'(chip_reset_o));
        master_clear_pin_n <= 1'b0;
        hold_chk(10, "chip_reset pin run");
        master_clear_pin_n <= 1'b1;
        wait_rel(40);
        flags(2'b11);
    endtask : t_master_clear_pin

    task automatic t_wdt_reset();
        @(posedge clk_sys_i);
        wdt_i <= 1'b1;
        @(posedge clk_sys_i);
        wdt_i <= 1'b0;
        wait_rel(40);
        flags(2'b01);
        chk("pc wdt", 32'h0, 32'(pc_o));
        chk("status wdt", 32'h01, 32'(status_o[7:3]));
    endtask : t_wdt_reset

    task automatic wake(input logic by_wdt, input logic ie,
                        input logic [12:0] epc, input logic [1:0] est);
        int i;
        @(posedge clk_sys_i);
        sleeping_i <= 1'b1;
        cur_pc_i <= 13'h0123;
        global_irq_enable <= ie;
        @(posedge clk_sys_i);
        wdt_i <= by_wdt;
        irq_wake_i <= ~by_wdt;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys_i);
            if (i == 0) begin
                wdt_i <= 1'b0;
                irq_wake_i <= 1'b0;
            end
            if (pc_load_o === 1'b1) break;
        end
        chk("pc wake", 32'(epc), 32'(pc_o));
        chk("status wake", 32'(est), 32'(status_o[4:3]));
        chk("option wake", 32'hff, 32'(option_o));
        flags(est);
        sleeping_i <= 1'b0;
    endtask : wake

    task automatic results();
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset_values();
        t_xtal_powerup();
        t_power_reset_status_rw();
        t_brownout();
        t_master_clear_pin();
        t_wdt_reset();
        wake(1'b1, 1'b0, 13'h0124, 2'b00);
        wake(1'b0, 1'b1, 13'h0004, 2'b10);
        wake(1'b0, 1'b0, 13'h0124, 2'b10);
        results();
    end
endmodule : rts_sequencer_test
